// [verilog/fga_pkg.sv]
package fga_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ              = 50;          // device clock rate
  localparam int OVR_DELAY_US         = 7000;        // enable and disable qualify time
  localparam int OVR_FULL             = 10;          // counter full range in samples
  localparam int OVR_SAMPLE_CYC       = OVR_DELAY_US * CLK_MHZ / OVR_FULL;
  localparam int OVR_HI_PCT           = 70;          // enable point, percent
  localparam int OVR_LO_PCT           = 30;          // disable point, percent
  localparam logic [3:0] OVR_MAX      = 4'(OVR_FULL);
  localparam logic [3:0] OVR_HI       = 4'(OVR_FULL * OVR_HI_PCT / 100);
  localparam logic [3:0] OVR_LO       = 4'(OVR_FULL * OVR_LO_PCT / 100);
  localparam int CSEL_DEG_US          = 1000;        // cell select deglitch time
  localparam int CSEL_DEG_CYC         = CSEL_DEG_US * CLK_MHZ;

  // ****************************************
  // cell select levels and counts
  // ****************************************
  localparam logic [1:0] CSEL_LOW     = 2'h0;        // below low level
  localparam logic [1:0] CSEL_MID     = 2'h1;        // within mid level
  localparam logic [1:0] CSEL_HIGH    = 2'h2;        // above high level
  localparam logic [2:0] CELLS_3      = 3'h3;
  localparam logic [2:0] CELLS_4      = 3'h4;
  localparam logic [2:0] CELLS_5      = 3'h5;
  localparam logic [4:0] CELL_MASK_3  = 5'h07;
  localparam logic [4:0] CELL_MASK_4  = 5'h0f;
  localparam logic [4:0] CELL_MASK_5  = 5'h1f;

  // state comparator modes
  typedef enum logic [1:0] {FGA_CMP_OFF, FGA_CMP_CHG_DET, FGA_CMP_DSG_DET} fga_cmp_t;

endpackage

// [verilog/fet_gate_arbiter.sv]
module fet_gate_arbiter
  import fga_pkg::*;
#(
  parameter int OVR_SAMPLE = OVR_SAMPLE_CYC,  // cycles between override samples
  parameter int CSEL_DEG   = CSEL_DEG_CYC     // cell select deglitch cycles
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       charge_override_in,      // sampled level, 1 = enabled
  input  wire logic       discharge_override_in,   // sampled level, 1 = enabled
  input  wire logic [1:0] cell_count_select,       // quantised select level
  input  wire logic       cell_high_voltage_fault,
  input  wire logic [4:0] cell_low_voltage_raw,    // per-cell low voltage flags
  input  wire logic       open_wire_fault,
  input  wire logic       charge_hot_fault,
  input  wire logic       charge_cold_fault,
  input  wire logic       discharge_hot_fault,
  input  wire logic       discharge_cold_fault,
  input  wire logic       discharge_overcurrent_1,
  input  wire logic       discharge_overcurrent_2,
  input  wire logic       short_circuit_discharge,
  input  wire logic       charge_overcurrent_fault,
  input  wire logic       deep_sleep_mode,
  input  wire logic       balancing_active,
  input  wire logic       sense_above_chg_thr,     // sense above charge threshold
  input  wire logic       sense_above_chg_hys,     // sense above charge thr minus hys
  input  wire logic       sense_below_dsg_thr,     // sense at or below discharge thr
  input  wire logic       sense_below_dsg_hys,     // sense at or below discharge thr plus hys
  output logic            charge_gate_drive,
  output logic            discharge_gate_drive,
  output logic            discharge_prot_enable,   // enables overcurrent 1/2 and short
  output logic            charge_prot_enable,      // charge overcurrent protection enable
  output fga_cmp_t        state_cmp_mode,
  output logic [2:0]      cell_count,
  output logic            cell_low_voltage_fault
);

  // ****************************************
  // override qualification
  // ****************************************
  logic [31:0] samp_cnt_r;                         // sample period timer
  logic        samp_tick;                          // one sample per period
  logic [3:0]  ovr_cnt_r [2];                      // 0 = charge, 1 = discharge
  logic        ovr_en_r  [2];                      // qualified enabled state
  logic [1:0]  ovr_raw;

  assign samp_tick = (samp_cnt_r == 32'(OVR_SAMPLE - 1));
  assign ovr_raw   = {discharge_override_in, charge_override_in};

  // sample period divider
  always_ff @(posedge clk) begin
    if (!rstn) begin
      samp_cnt_r <= 32'h0;
    end else begin
      samp_cnt_r <= samp_tick ? 32'h0 : samp_cnt_r + 32'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ovr
      logic [3:0] cnt_nxt;
      assign cnt_nxt = !samp_tick ? ovr_cnt_r[gi] :
                       ovr_raw[gi] ? ((ovr_cnt_r[gi] == OVR_MAX) ? OVR_MAX
                                                                 : ovr_cnt_r[gi] + 4'h1) :
                       ((ovr_cnt_r[gi] == 4'h0) ? 4'h0 : ovr_cnt_r[gi] - 4'h1);
      // counter value update
      always_ff @(posedge clk) begin
        if (!rstn) begin
          ovr_cnt_r[gi] <= 4'h0;
        end else begin
          ovr_cnt_r[gi] <= cnt_nxt;
        end
      end
      always_ff @(posedge clk) begin
        if (!rstn) begin
          ovr_en_r[gi] <= 1'b0;   // drives off until qualified at power-up
        end else if (ovr_cnt_r[gi] > OVR_HI) begin
          ovr_en_r[gi] <= 1'b1;
        end else if (ovr_cnt_r[gi] < OVR_LO) begin
          ovr_en_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // cell count selection
  // ****************************************
  logic [1:0]  csel_last_r;                        // level seen last cycle
  logic [31:0] csel_cnt_r;                         // persistence counter
  logic [2:0]  cell_count_r;
  logic [4:0]  cell_mask;

  // decode used cells from the count into the low voltage mask
  function automatic logic [4:0] cells_to_mask(input logic [2:0] n);
    case (n)
      CELLS_3: cells_to_mask = CELL_MASK_3;
      CELLS_4: cells_to_mask = CELL_MASK_4;
      default: cells_to_mask = CELL_MASK_5;
    endcase
  endfunction

  function automatic logic [2:0] level_to_cells(input logic [1:0] lv);
    case (lv)
      CSEL_LOW: level_to_cells = CELLS_3;
      CSEL_MID: level_to_cells = CELLS_4;
      default:  level_to_cells = CELLS_5;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      csel_last_r  <= CSEL_HIGH;
      csel_cnt_r   <= 32'h0;
      cell_count_r <= CELLS_5;
    end else begin
      csel_last_r <= cell_count_select;
      if (cell_count_select != csel_last_r) begin
        csel_cnt_r <= 32'h0;
      end else if (csel_cnt_r < 32'(CSEL_DEG - 1)) begin
        csel_cnt_r <= csel_cnt_r + 32'h1;
      end else begin
        cell_count_r <= level_to_cells(csel_last_r);
      end
    end
  end

  assign cell_mask = cells_to_mask(cell_count_r);

  // ****************************************
  // gate arbitration
  // ****************************************
  logic uv_any;
  logic common_flt;                                // faults blocking both gates
  logic dsg_flt;                                   // discharge_gate_block sources
  logic chg_flt;                                   // charge_gate_block sources
  logic discharge_gate_block;
  logic charge_gate_block;
  logic dsg_on_r;                                  // comparator charge-seen latch
  logic chg_on_r;                                  // comparator discharge-seen latch
  logic dsg_nxt;
  logic chg_nxt;

  assign uv_any     = |(cell_low_voltage_raw & cell_mask);
  assign common_flt = open_wire_fault | discharge_hot_fault | discharge_cold_fault |
                      discharge_overcurrent_1 | discharge_overcurrent_2 |
                      short_circuit_discharge | charge_overcurrent_fault;
  assign dsg_flt    = uv_any | common_flt;
  assign chg_flt    = cell_high_voltage_fault | charge_hot_fault | charge_cold_fault |
                      common_flt;
  // upper stack faults arrive via overrides
  assign discharge_gate_block = dsg_flt | !ovr_en_r[1];
  assign charge_gate_block    = chg_flt | !ovr_en_r[0];

  always_comb begin
    dsg_nxt = 1'b0;
    if (sense_above_chg_thr) begin
      dsg_nxt = 1'b1;
    end else if (sense_above_chg_hys) begin
      dsg_nxt = dsg_on_r;
    end
  end

  always_comb begin
    chg_nxt = 1'b0;
    if (sense_below_dsg_thr) begin
      chg_nxt = 1'b1;
    end else if (sense_below_dsg_hys) begin
      chg_nxt = chg_on_r;
    end
  end

  logic body_dsg;                                  // discharge gate via comparator
  logic body_chg;                                  // charge gate via comparator
  logic dsg_drive_nxt;
  logic chg_drive_nxt;
  fga_cmp_t cmp_nxt;

  assign body_dsg = discharge_gate_block && !charge_gate_block && dsg_on_r;
  assign body_chg = charge_gate_block && !discharge_gate_block && chg_on_r;

  assign dsg_drive_nxt = !deep_sleep_mode && (!discharge_gate_block || body_dsg);
  assign chg_drive_nxt = !deep_sleep_mode && (!charge_gate_block || body_chg);

  assign cmp_nxt = deep_sleep_mode ? FGA_CMP_OFF :
                   (charge_gate_block && !discharge_gate_block) ? FGA_CMP_DSG_DET :
                   (discharge_gate_block && !charge_gate_block) ? FGA_CMP_CHG_DET :
                   (!charge_gate_block && balancing_active) ? FGA_CMP_CHG_DET :
                   FGA_CMP_OFF;

  // comparator latches and registered outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dsg_on_r              <= 1'b0;
      chg_on_r              <= 1'b0;
      discharge_gate_drive  <= 1'b0;
      charge_gate_drive     <= 1'b0;
      discharge_prot_enable <= 1'b0;
      charge_prot_enable    <= 1'b1;
      state_cmp_mode        <= FGA_CMP_OFF;
      cell_count            <= CELLS_5;
      cell_low_voltage_fault<= 1'b0;
    end else begin
      dsg_on_r              <= dsg_nxt;
      chg_on_r              <= chg_nxt;
      discharge_gate_drive  <= dsg_drive_nxt;
      charge_gate_drive     <= chg_drive_nxt;
      discharge_prot_enable <= dsg_drive_nxt;
      charge_prot_enable    <= 1'b1;
      state_cmp_mode        <= cmp_nxt;
      cell_count            <= cell_count_r;
      cell_low_voltage_fault<= uv_any;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_dsg_block;
    @(posedge clk) disable iff (!rstn)
      (deep_sleep_mode || (dsg_flt && charge_gate_block)) |=> !discharge_gate_drive;
  endproperty
  a_dsg_block: assert property (p_dsg_block)
    else $error("discharge gate on while blocked");

  property p_chg_block;
    @(posedge clk) disable iff (!rstn)
      (deep_sleep_mode || (chg_flt && discharge_gate_block)) |=> !charge_gate_drive;
  endproperty
  a_chg_block: assert property (p_chg_block)
    else $error("charge gate on while blocked");

  property p_prot;
    @(posedge clk) disable iff (!rstn)
      discharge_prot_enable == discharge_gate_drive;
  endproperty
  a_prot: assert property (p_prot)
    else $error("discharge protection mismatch");

  property p_cmp_on;
    @(posedge clk) disable iff (!rstn)
      (!deep_sleep_mode && charge_gate_block && !discharge_gate_block)
        |=> state_cmp_mode == FGA_CMP_DSG_DET;
  endproperty
  a_cmp_on: assert property (p_cmp_on)
    else $error("comparator not in discharge detect");

  property p_cmp_off;
    @(posedge clk) disable iff (!rstn)
      (charge_gate_block && discharge_gate_block) |=> state_cmp_mode == FGA_CMP_OFF;
  endproperty
  a_cmp_off: assert property (p_cmp_off)
    else $error("comparator on with both blocked");

  property p_body_chg;
    @(posedge clk) disable iff (!rstn)
      (!deep_sleep_mode && charge_gate_block && !discharge_gate_block && chg_on_r)
        |=> charge_gate_drive;
  endproperty
  a_body_chg: assert property (p_body_chg)
    else $error("charge gate not rescued");

  property p_body_dsg;
    @(posedge clk) disable iff (!rstn)
      (!deep_sleep_mode && discharge_gate_block && !charge_gate_block && dsg_on_r)
        |=> discharge_gate_drive;
  endproperty
  a_body_dsg: assert property (p_body_dsg)
    else $error("discharge gate not rescued");

  property p_ovr_en;
    @(posedge clk) disable iff (!rstn)
      (ovr_cnt_r[0] > OVR_HI) |=> ovr_en_r[0];
  endproperty
  a_ovr_en: assert property (p_ovr_en)
    else $error("override not enabled");

  property p_ovr_dis;
    @(posedge clk) disable iff (!rstn)
      (ovr_cnt_r[1] < OVR_LO) |=> !ovr_en_r[1];
  endproperty
  a_ovr_dis: assert property (p_ovr_dis)
    else $error("override not disabled");

  property p_sat;
    @(posedge clk) disable iff (!rstn)
      ovr_cnt_r[0] <= OVR_MAX && ovr_cnt_r[1] <= OVR_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("override counter overflow");

  // a glitch that leaves the count between the points must not flip the state
  property p_ovr_hold;
    @(posedge clk) disable iff (!rstn)
      (ovr_cnt_r[1] >= OVR_LO && ovr_cnt_r[1] <= OVR_HI) |=> $stable(ovr_en_r[1]);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("override state changed between points");

  property p_uv_mask;
    @(posedge clk) disable iff (!rstn)
      (cell_count_r == CELLS_3 && cell_low_voltage_raw[2:0] == 3'h0)
        |=> !cell_low_voltage_fault;
  endproperty
  a_uv_mask: assert property (p_uv_mask)
    else $error("unused cell raised low voltage");

  property p_cell_deg;
    @(posedge clk) disable iff (!rstn)
      (cell_count_select != csel_last_r) |=> $stable(cell_count_r);
  endproperty
  a_cell_deg: assert property (p_cell_deg)
    else $error("cell count changed on a moving select level");

endmodule // fet_gate_arbiter

// [tb/fga_upper_stack.sv]
// ****************************************
// upper stacked protector model
// ****************************************
module fga_upper_stack (
  input  wire logic clk,                    // device clock
  input  wire logic upper_chg_on,           // upper device charge gate state
  input  wire logic upper_dsg_on,           // upper device discharge gate state
  input  wire logic slow,                   // long wiring lag when high
  output logic      charge_override_in,     // level seen at the lower device
  output logic      discharge_override_in   // level seen at the lower device
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] chg_q_r;   // lag line for the charge gate level
  logic [2:0] dsg_q_r;   // lag line for the discharge gate level

  // upper gate levels travel down through a resistive, filtered path
  always_ff @(posedge clk) begin
    chg_q_r <= {chg_q_r[1:0], upper_chg_on};
    dsg_q_r <= {dsg_q_r[1:0], upper_dsg_on};
  end

  assign charge_override_in    = slow ? chg_q_r[2] : chg_q_r[0];
  assign discharge_override_in = slow ? dsg_q_r[2] : dsg_q_r[0];
endmodule // fga_upper_stack

// [tb/fet_gate_arbiter_bench.sv]
`define FGA_CHECK(nm, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module fet_gate_arbiter_bench
  import fga_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  localparam int OVR  = 4;   // short override sample spacing keeps the run brief
  localparam int CDEG = 8;   // short cell select deglitch
  logic       clk, rstn, upper_chg_on, upper_dsg_on, slow, bal, sleep;
  logic       chg_ovr, dsg_ovr, cg, dg, dpe, cpe, uvf;
  logic [9:0] flt;          // hv, ow, chot, ccold, dhot, dcold, discharge_overcurrent_1, discharge_overcurrent_2, short, occ
  logic [4:0] uv_raw;       // per-cell low voltage flags
  logic [3:0] sense;        // above chg thr, above chg hys, below dsg thr, below dsg hys
  logic [1:0] sel;          // cell count select level
  logic [2:0] cnt;          // configured cell count
  fga_cmp_t   cmp;          // comparator mode seen
  logic       m_dlat, m_clat;   // model discharge and charge detect latches
  logic [2:0] m_cells;      // model cell count
  logic [31:0] rnd;         // xorshift state
  int         miscompares, n_tests;
  logic [3:0] sense_tab [5] = '{4'h0, 4'h3, 4'hc, 4'h1, 4'h4};   // idle, dsg, chg, bands

  fga_upper_stack fga_upper_stack_inst (.clk(clk), .upper_chg_on(upper_chg_on),
    .upper_dsg_on(upper_dsg_on), .slow(slow), .charge_override_in(chg_ovr),
    .discharge_override_in(dsg_ovr));

  fet_gate_arbiter #(.OVR_SAMPLE(OVR), .CSEL_DEG(CDEG)) fet_gate_arbiter_inst (
    .clk(clk), .rstn(rstn), .charge_override_in(chg_ovr), .discharge_override_in(dsg_ovr),
    .cell_count_select(sel), .cell_high_voltage_fault(flt[0]), .cell_low_voltage_raw(uv_raw),
    .open_wire_fault(flt[1]), .charge_hot_fault(flt[2]), .charge_cold_fault(flt[3]),
    .discharge_hot_fault(flt[4]), .discharge_cold_fault(flt[5]),
    .discharge_overcurrent_1(flt[6]), .discharge_overcurrent_2(flt[7]),
    .short_circuit_discharge(flt[8]), .charge_overcurrent_fault(flt[9]),
    .deep_sleep_mode(sleep), .balancing_active(bal), .sense_above_chg_thr(sense[3]),
    .sense_above_chg_hys(sense[2]), .sense_below_dsg_thr(sense[1]),
    .sense_below_dsg_hys(sense[0]), .charge_gate_drive(cg), .discharge_gate_drive(dg),
    .discharge_prot_enable(dpe), .charge_prot_enable(cpe), .state_cmp_mode(cmp),
    .cell_count(cnt), .cell_low_voltage_fault(uvf));

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // waits whole cycles, landing just after an edge where outputs are settled
  task automatic cyc(int n);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask

  // steady-state model; only valid once inputs have been held long enough
  task automatic check_all();
    logic [4:0] mask;
    logic       uv, cf, df, ec, ed;
    fga_cmp_t   em;
    mask = (m_cells == CELLS_3) ? CELL_MASK_3 : (m_cells == CELLS_4) ? CELL_MASK_4 : CELL_MASK_5;
    uv = |(uv_raw & mask);
    df = uv | flt[1] | (|flt[9:4]) | !upper_dsg_on;
    cf = (|flt) | !upper_chg_on;
    if (sense[1]) m_dlat = 1'b1;
    else if (!sense[0]) m_dlat = 1'b0;
    if (sense[3]) m_clat = 1'b1;
    else if (!sense[2]) m_clat = 1'b0;
    ec = 1'b1;
    ed = 1'b1;
    em = bal ? FGA_CMP_CHG_DET : FGA_CMP_OFF;
    if (sleep || (cf && df)) begin
      {ec, ed} = 2'b00;
      em = FGA_CMP_OFF;
    end else if (cf) begin
      ec = m_dlat;
      em = FGA_CMP_DSG_DET;
    end else if (df) begin
      ed = m_clat;
      em = FGA_CMP_CHG_DET;
    end
    `FGA_CHECK("charge_gate_drive", ec, cg)
    `FGA_CHECK("discharge_gate_drive", ed, dg)
    `FGA_CHECK("discharge_prot_enable", ed, dpe)
    `FGA_CHECK("charge_prot_enable", 1'b1, cpe)
    `FGA_CHECK("state_cmp_mode", em, cmp)
    `FGA_CHECK("cell_count", m_cells, cnt)
    `FGA_CHECK("cell_low_voltage_fault", uv, uvf)
  endtask

  // holds inputs long enough for qualifiers and deglitch, then compares
  task automatic step(bit ovr_change);
    cyc(ovr_change ? 12 * OVR : CDEG + 6);
    m_cells = (sel == 2'h0) ? CELLS_3 : (sel == 2'h1) ? CELLS_4 : CELLS_5;
    check_all();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  // watchdog cuts a hang short
  initial begin
    #1_000_000;
    miscompares++;
    wrap_up();
  end

  initial begin
    logic lc, ld;
    logic [31:0] r2;
    {clk, rstn, slow, bal, sleep, flt, uv_raw, sense} = '0;
    {upper_chg_on, upper_dsg_on, sel, m_dlat, m_clat, m_cells} = {2'b11, 2'h2, 2'b00, CELLS_5};
    {miscompares, n_tests, rnd} = {32'h0, 32'h0, 32'h1017e20b};
    cyc(10);
    rstn = 1'b1;
    `FGA_CHECK("cell_count", CELLS_5, cnt)
    cyc(5 * OVR);
    // qualification must not be complete after five samples
    `FGA_CHECK("charge_gate_drive", 1'b0, cg)
    `FGA_CHECK("discharge_gate_drive", 1'b0, dg)
    step(1);
    cyc(8 * OVR);
    // short disabled glitch leaves the count between the two points
    upper_dsg_on = 1'b0;
    cyc(3 * OVR);
    upper_dsg_on = 1'b1;
    `FGA_CHECK("discharge_gate_drive", 1'b1, dg)
    cyc(4 * OVR);
    upper_dsg_on = 1'b0;
    cyc(5 * OVR);
    `FGA_CHECK("discharge_gate_drive", 1'b1, dg)
    step(1);
    // charging rescue, band hold, then idle release of the discharge gate
    for (int i = 0; i < 3; i++) begin
      sense = sense_tab[i == 0 ? 2 : (i == 1 ? 4 : 0)];
      step(0);
    end
    upper_dsg_on = 1'b1;
    step(1);
    // every select level, with low voltage flags only on the upper cells
    uv_raw = 5'h18;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      step(0);
    end
    sel = 2'h0;
    cyc(CDEG / 2);
    sel = 2'h3;
    step(0);
    uv_raw = 5'h00;
    // random fault, sense and override mixes
    for (int i = 0; i < 150; i++) begin
      {lc, ld} = {upper_chg_on, upper_dsg_on};
      rnd = xs(rnd);
      r2 = xs(rnd);
      rnd = r2;
      flt = r2[9:0] & r2[19:10] & r2[29:20];
      r2 = xs(r2);
      rnd = r2;
      {sel, uv_raw, sleep, bal} = {r2[1:0], r2[6:2] & r2[11:7], &r2[14:12], r2[15]};
      {upper_chg_on, upper_dsg_on, slow} = {|r2[17:16], |r2[19:18], r2[20]};
      sense = sense_tab[r2[23:21] % 5];
      step((lc != upper_chg_on) || (ld != upper_dsg_on));
    end
    // second reset in mid-run
    rstn = 1'b0;
    cyc(1);
    `FGA_CHECK("charge_gate_drive", 1'b0, cg)
    `FGA_CHECK("cell_count", CELLS_5, cnt)
    rstn = 1'b1;
    // qualification restarts from zero, so both gates stay off for a while
    cyc(5 * OVR);
    `FGA_CHECK("charge_gate_drive", 1'b0, cg)
    `FGA_CHECK("discharge_gate_drive", 1'b0, dg)
    `FGA_CHECK("state_cmp_mode", FGA_CMP_OFF, cmp)
    wrap_up();
  end
endmodule // fet_gate_arbiter_bench
